/* File: charger_status_chk.sv */
// Purpose: concurrent checks on the status bank read port
// Assumes: a condition held four clocks is visible to a read
// Notes:   live bits pass two syncs and one register
`timescale 1ns/100ps
module charger_status_chk (
  input wire logic                           mclk_i,
  input wire logic                           rst_n_i,
  input wire charger_status_pkg::live_cond_t cond_i,
  input wire charger_status_pkg::mode_t      mode_i,
  input wire logic [7:0]                     s_axi_araddr_i,
  input wire logic                           s_axi_arvalid_i,
  input wire logic                           s_axi_arready_o,
  input wire logic [31:0]                    s_axi_rdata_o,
  input wire logic                           s_axi_rvalid_o
);
  // ==========================================================
  // read decode
  wire [31:0] d = s_axi_rdata_o;
  wire tk = s_axi_arvalid_i && s_axi_arready_o;
  wire t3 = tk && s_axi_araddr_i == charger_status_pkg::ADDR_STATUS_THREE;
  wire t4 = tk && s_axi_araddr_i == charger_status_pkg::ADDR_STATUS_FOUR;
  wire t0 = tk && s_axi_araddr_i == charger_status_pkg::ADDR_FAULT_ZERO;
  wire os0 = !mode_i.adc_one_shot;
  wire fw0 = !mode_i.forward_mode;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // checks
  hi_zero_a: assert property (s_axi_rvalid_o |-> d[31:8] == 24'h0)
    else $error("high read bits set");
  rsv_three_a: assert property (t3 |=> d[0] == 1'h0)
    else $error("reserved bit set");
  rsv_four_a: assert property (t4 |=> d[7:5] == 3'h0)
    else $error("reserved field set");
  done_gate_a: assert property (os0[*3] ##0 t3 |=> !d[5])
    else $error("done shown outside one-shot");
  sys_gate_a: assert property (fw0[*3] ##0 t3 |=> !d[4])
    else $error("regulation shown outside forward");
  cold_zone_a: assert property (cond_i[11][*4] ##0 t4 |=> d[3])
    else $error("cold zone missing");
  hot_zone_a: assert property (cond_i[8][*4] ##0 t4 |=> d[0])
    else $error("hot zone missing");
  bus_ovp_a: assert property (cond_i[6][*4] ##0 t0 |=> d[6])
    else $error("bus overvoltage missing");
  cover property (t3);
  cover property (t4);
  cover property (t0);
endmodule : charger_status_chk

/* File: charger_status_fault_regs.sv */
// Purpose: three read-only status/fault registers on AXI4-Lite
// Assumes: live conditions are asynchronous levels; modes are on mclk_i
// Notes:   bits track their conditions, no latching; writes ignored
//
// Summary of operation
// RULE1 - bit7 status three: input2 blocking pair fitted
// RULE2 - bit6 status three: input1 blocking pair fitted
// RULE3 - bit5: conversion done, one-shot mode only
// RULE4 - bit4: minimum system regulation in forward mode
// RULE5 - bit3: fast-charge safety timer expired
// RULE6 - bit2: trickle-charge safety timer expired
// RULE7 - bit1 precharge timer expired; bit0 reserved
// RULE8 - status four bit4 battery too low; 7-5 reserved
// RULE9 - status four bit3: thermistor cold zone
// RULE10 - status four bit2: thermistor cool zone
// RULE11 - status four bit1: thermistor warm zone
// RULE12 - status four bit0: thermistor hot zone
// RULE13 - fault bit7: discharge current limiting active
// RULE14 - fault bit6: input bus overvoltage
// RULE15 - fault bit5: battery overvoltage
// RULE16 - fault bit4: input overcurrent
// RULE17 - fault bit3: battery overcurrent
// RULE18 - fault bit2: converter overcurrent
// RULE19 - fault bit1 second input, bit0 first input OVP
// RULE20 - all read-only, 8 bits, zero at reset
// RULE21 - bits follow live conditions, never latched
`timescale 1ns/100ps
module charger_status_fault_regs (
  input  wire logic                         mclk_i,
  input  wire logic                         rst_n_i,
  input  wire charger_status_pkg::live_cond_t cond_i,
  input  wire charger_status_pkg::mode_t    mode_i,
  input  wire logic [7:0]                   s_axi_awaddr_i,
  input  wire logic                         s_axi_awvalid_i,
  output logic                              s_axi_awready_o,
  input  wire logic [31:0]                  s_axi_wdata_i,
  input  wire logic [3:0]                   s_axi_wstrb_i,
  input  wire logic                         s_axi_wvalid_i,
  output logic                              s_axi_wready_o,
  output logic [1:0]                        s_axi_bresp_o,
  output logic                              s_axi_bvalid_o,
  input  wire logic                         s_axi_bready_i,
  input  wire logic [7:0]                   s_axi_araddr_i,
  input  wire logic                         s_axi_arvalid_i,
  output logic                              s_axi_arready_o,
  output logic [31:0]                       s_axi_rdata_o,
  output logic [1:0]                        s_axi_rresp_o,
  output logic                              s_axi_rvalid_o,
  input  wire logic                         s_axi_rready_i
);

  localparam int CW = charger_status_pkg::COND_W;
  localparam int RW = charger_status_pkg::REG_W;

  // ==========================================================
  // input synchronisers
  // each bit synced alone; a multi-bit zone change may show
  // one cycle of mixed old/new bits, acceptable for status
  logic [CW-1:0] sync1_r;
  logic [CW-1:0] sync2_r;

  genvar g;
  generate
    for (g = 0; g < CW; g++) begin : g_sync
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          sync1_r[g] <= 1'b0;
          sync2_r[g] <= 1'b0;
        end else begin
          sync1_r[g] <= cond_i[g];
          sync2_r[g] <= sync1_r[g];
        end
      end
    end
  endgenerate

  charger_status_pkg::live_cond_t c;
  assign c = charger_status_pkg::live_cond_t'(sync2_r);

  // ==========================================================
  // register contents
  wire [RW-1:0] status_three_nxt;
  wire [RW-1:0] status_four_nxt;
  wire [RW-1:0] fault_zero_nxt;
  wire          adc_done_bit;
  wire          vsys_bit;

  // RULE3 one-shot qualified
  assign adc_done_bit = c.adc_conversion_done & mode_i.adc_one_shot;
  // RULE4 forward mode only
  assign vsys_bit = c.min_system_regulating & mode_i.forward_mode;

  // qualifiers are same-clock, so they skip the synchronisers
  // one assign per field keeps each field next to its rule

  // RULE1 second pair placement
  assign status_three_nxt[charger_status_pkg::POS_PAIR2] =
    c.input2_blocking_pair_fitted;

  // RULE2 first pair placement
  assign status_three_nxt[charger_status_pkg::POS_PAIR1] =
    c.input1_blocking_pair_fitted;

  // RULE3 gated done bit
  assign status_three_nxt[charger_status_pkg::POS_ADC_DONE] =
    adc_done_bit;

  // RULE4 gated regulation bit
  assign status_three_nxt[charger_status_pkg::POS_MIN_SYS] =
    vsys_bit;

  // RULE5 fast timer expiry
  assign status_three_nxt[charger_status_pkg::POS_FAST_TMR] =
    c.fast_timer_expired;

  // RULE6 trickle timer expiry
  assign status_three_nxt[charger_status_pkg::POS_TRICKLE_TMR] =
    c.trickle_timer_expired;

  // RULE7 precharge timer expiry
  assign status_three_nxt[charger_status_pkg::POS_PRE_TMR] =
    c.precharge_timer_expired;

  // RULE7 reserved bit zero
  assign status_three_nxt[charger_status_pkg::POS_RSV_THREE] =
    1'b0;

  // RULE8 reserved field zero
  assign status_four_nxt[charger_status_pkg::POS_RSV_FOUR_HI:
                         charger_status_pkg::POS_RSV_FOUR_LO] = 3'h0;

  // RULE8 battery low flag
  assign status_four_nxt[charger_status_pkg::POS_BATT_LOW] =
    c.battery_low_for_boost;

  // RULE9 cold zone
  assign status_four_nxt[charger_status_pkg::POS_COLD] =
    c.thermistor_cold_zone;

  // RULE10 cool zone
  assign status_four_nxt[charger_status_pkg::POS_COOL] =
    c.thermistor_cool_zone;

  // RULE11 warm zone
  assign status_four_nxt[charger_status_pkg::POS_WARM] =
    c.thermistor_warm_zone;

  // RULE12 hot zone
  assign status_four_nxt[charger_status_pkg::POS_HOT] =
    c.thermistor_hot_zone;

  // RULE13 discharge limiting
  assign fault_zero_nxt[charger_status_pkg::POS_DISCHARGE] =
    c.discharge_current_limiting;

  // RULE14 bus overvoltage
  assign fault_zero_nxt[charger_status_pkg::POS_BUS_OV] =
    c.input_bus_overvoltage;

  // RULE15 battery overvoltage
  assign fault_zero_nxt[charger_status_pkg::POS_BAT_OV] =
    c.battery_overvoltage;

  // RULE16 input overcurrent
  assign fault_zero_nxt[charger_status_pkg::POS_IN_OC] =
    c.input_overcurrent;

  // RULE17 battery overcurrent
  assign fault_zero_nxt[charger_status_pkg::POS_BAT_OC] =
    c.battery_overcurrent;

  // RULE18 converter overcurrent
  assign fault_zero_nxt[charger_status_pkg::POS_CONV_OC] =
    c.converter_overcurrent;

  // RULE19 second input overvoltage
  assign fault_zero_nxt[charger_status_pkg::POS_IN2_OV] =
    c.second_input_overvoltage;

  // RULE19 first input overvoltage
  assign fault_zero_nxt[charger_status_pkg::POS_IN1_OV] =
    c.first_input_overvoltage;

  logic [RW-1:0] status_three_r;
  logic [RW-1:0] status_four_r;
  logic [RW-1:0] fault_zero_r;

  // RULE21 reload every cycle
  // RULE20 zero at reset, no write path
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_three_r <= charger_status_pkg::REG_RESET;
    end else begin
      status_three_r <= status_three_nxt;
    end
  end

  // RULE21 status four live copy
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_four_r <= charger_status_pkg::REG_RESET;
    end else begin
      status_four_r <= status_four_nxt;
    end
  end

  // RULE21 fault live copy
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_zero_r <= charger_status_pkg::REG_RESET;
    end else begin
      fault_zero_r <= fault_zero_nxt;
    end
  end

  // ==========================================================
  // write channel: both halves taken in any order, then response
  logic       aw_held_r;
  logic       w_held_r;
  logic [7:0] awaddr_r;
  logic       bvalid_r;
  logic [1:0] bresp_r;

  wire aw_take;
  wire w_take;
  wire aw_have;
  wire w_have;
  wire wr_fire;
  wire [7:0] wr_addr;

  assign s_axi_awready_o = !aw_held_r && !bvalid_r;
  assign s_axi_wready_o  = !w_held_r && !bvalid_r;
  assign aw_take = s_axi_awvalid_i && s_axi_awready_o;
  assign w_take  = s_axi_wvalid_i && s_axi_wready_o;
  assign aw_have = aw_held_r || aw_take;
  assign w_have  = w_held_r || w_take;
  assign wr_fire = aw_have && w_have;
  assign wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr_i;

  // ==========================================================
  // write address decode
  // low address bits ignored: byte lanes of a word alias
  wire [7:0] wr_word;
  wire       wr_hit_three;
  wire       wr_hit_four;
  wire       wr_hit_fault;
  wire       wr_mapped;

  assign wr_word      = wr_addr & charger_status_pkg::WORD_MASK;
  assign wr_hit_three = wr_word == charger_status_pkg::ADDR_STATUS_THREE;
  assign wr_hit_four  = wr_word == charger_status_pkg::ADDR_STATUS_FOUR;
  assign wr_hit_fault = wr_word == charger_status_pkg::ADDR_FAULT_ZERO;
  assign wr_mapped    = wr_hit_three || wr_hit_four || wr_hit_fault;

  // ==========================================================
  // write channel next state
  wire       aw_held_nxt;
  wire       w_held_nxt;
  wire [7:0] awaddr_nxt;
  wire       bvalid_nxt;
  wire [1:0] bresp_nxt;
  wire       b_done;

  assign b_done      = bvalid_r && s_axi_bready_i;
  assign aw_held_nxt = !wr_fire && aw_have;
  assign w_held_nxt  = !wr_fire && w_have;
  assign awaddr_nxt  = aw_take ? s_axi_awaddr_i : awaddr_r;
  // readies are low while bvalid, so fire and drain never meet
  assign bvalid_nxt  = wr_fire || (bvalid_r && !b_done);
  assign bresp_nxt   = !wr_fire ? bresp_r :
                       wr_mapped ? charger_status_pkg::RESP_OKAY :
                       charger_status_pkg::RESP_SLVERR;

  // RULE20 write data and strobes discarded
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 8'h00;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      awaddr_r  <= awaddr_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bvalid_r <= 1'b0;
      bresp_r  <= charger_status_pkg::RESP_OKAY;
    end else begin
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
    end
  end

  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o  = bresp_r;

  // ==========================================================
  // read channel
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  wire        ar_take;
  wire [7:0]  rd_word;
  wire [RW-1:0] rd_sel;

  assign s_axi_arready_o = !rvalid_r;
  assign ar_take = s_axi_arvalid_i && s_axi_arready_o;
  assign rd_word = s_axi_araddr_i & charger_status_pkg::WORD_MASK;
  assign rd_sel =
    (rd_word == charger_status_pkg::ADDR_STATUS_THREE) ? status_three_r :
    (rd_word == charger_status_pkg::ADDR_STATUS_FOUR)  ? status_four_r  :
    (rd_word == charger_status_pkg::ADDR_FAULT_ZERO)   ? fault_zero_r   :
    charger_status_pkg::REG_RESET;

  // ==========================================================
  // read address decode
  wire rd_hit_three;
  wire rd_hit_four;
  wire rd_hit_fault;
  wire rd_mapped;

  assign rd_hit_three = rd_word == charger_status_pkg::ADDR_STATUS_THREE;
  assign rd_hit_four  = rd_word == charger_status_pkg::ADDR_STATUS_FOUR;
  assign rd_hit_fault = rd_word == charger_status_pkg::ADDR_FAULT_ZERO;
  assign rd_mapped    = rd_hit_three || rd_hit_four || rd_hit_fault;

  // ==========================================================
  // read channel next state
  wire        rvalid_nxt;
  wire [31:0] rdata_nxt;
  wire [1:0]  rresp_nxt;
  wire        r_done;

  assign r_done     = rvalid_r && s_axi_rready_i;
  assign rvalid_nxt = ar_take || (rvalid_r && !r_done);
  // unmapped words read zero, flagged by the error response
  assign rdata_nxt  = ar_take ? {24'h00_0000, rd_sel} : rdata_r;
  assign rresp_nxt  = !ar_take ? rresp_r :
                      rd_mapped ? charger_status_pkg::RESP_OKAY :
                      charger_status_pkg::RESP_SLVERR;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= rvalid_nxt;
    end
  end

  // RULE21 read returns present state
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= 32'h0000_0000;
      rresp_r <= charger_status_pkg::RESP_OKAY;
    end else begin
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o  = rdata_r;
  assign s_axi_rresp_o  = rresp_r;

endmodule : charger_status_fault_regs

/* File: charger_status_pkg.sv */
// Purpose: constants and carriers for the charger status/fault bank
// Assumes: 8-bit byte addresses, 32-bit AXI4-Lite data
// Notes:   printed offsets are word indices; byte address is 4x index
package charger_status_pkg;

  // ==========================================================
  // bus geometry
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 32;
  localparam int          REG_W      = 8;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================
  // register indices and byte addresses
  localparam logic [7:0]  IDX_STATUS_THREE = 8'h1e;
  localparam logic [7:0]  IDX_STATUS_FOUR  = 8'h1f;
  localparam logic [7:0]  IDX_FAULT_ZERO   = 8'h20;
  localparam logic [7:0]  ADDR_STATUS_THREE = IDX_STATUS_THREE * 8'h04;
  localparam logic [7:0]  ADDR_STATUS_FOUR  = IDX_STATUS_FOUR * 8'h04;
  localparam logic [7:0]  ADDR_FAULT_ZERO   = IDX_FAULT_ZERO * 8'h04;
  localparam logic [7:0]  WORD_MASK         = 8'hfc;
  localparam logic [7:0]  REG_RESET         = 8'h00;

  // ==========================================================
  // bit positions within each register
  localparam int          POS_PAIR2         = 7;
  localparam int          POS_PAIR1         = 6;
  localparam int          POS_ADC_DONE      = 5;
  localparam int          POS_MIN_SYS       = 4;
  localparam int          POS_FAST_TMR      = 3;
  localparam int          POS_TRICKLE_TMR   = 2;
  localparam int          POS_PRE_TMR       = 1;
  localparam int          POS_RSV_THREE     = 0;
  localparam int          POS_RSV_FOUR_HI   = 7;
  localparam int          POS_RSV_FOUR_LO   = 5;
  localparam int          POS_BATT_LOW      = 4;
  localparam int          POS_COLD          = 3;
  localparam int          POS_COOL          = 2;
  localparam int          POS_WARM          = 1;
  localparam int          POS_HOT           = 0;
  localparam int          POS_DISCHARGE     = 7;
  localparam int          POS_BUS_OV        = 6;
  localparam int          POS_BAT_OV        = 5;
  localparam int          POS_IN_OC         = 4;
  localparam int          POS_BAT_OC        = 3;
  localparam int          POS_CONV_OC       = 2;
  localparam int          POS_IN2_OV        = 1;
  localparam int          POS_IN1_OV        = 0;

  // ==========================================================
  // live conditions from the analog side, one bit each
  typedef struct packed {
    logic input2_blocking_pair_fitted;
    logic input1_blocking_pair_fitted;
    logic adc_conversion_done;
    logic min_system_regulating;
    logic fast_timer_expired;
    logic trickle_timer_expired;
    logic precharge_timer_expired;
    logic battery_low_for_boost;
    logic thermistor_cold_zone;
    logic thermistor_cool_zone;
    logic thermistor_warm_zone;
    logic thermistor_hot_zone;
    logic discharge_current_limiting;
    logic input_bus_overvoltage;
    logic battery_overvoltage;
    logic input_overcurrent;
    logic battery_overcurrent;
    logic converter_overcurrent;
    logic second_input_overvoltage;
    logic first_input_overvoltage;
  } live_cond_t;

  localparam int COND_W = $bits(live_cond_t);

  // mode qualifiers from on-chip logic, same clock
  typedef struct packed {
    logic adc_one_shot;
    logic forward_mode;
  } mode_t;

endpackage : charger_status_pkg

/* File: test_charger_status_fault_regs.sv */
// Purpose: self-checking bench for the status and fault bank
// Assumes: conditions settle within four clocks
// Notes:   writes must leave every bit alone
`timescale 1ns/100ps
module test_charger_status_fault_regs;
  logic mclk_i, rst_n_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i;
  logic s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i;
  logic s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  charger_status_pkg::live_cond_t cond_i;
  charger_status_pkg::mode_t mode_i;
  localparam logic [7:0] A3 = charger_status_pkg::ADDR_STATUS_THREE;
  localparam logic [7:0] A4 = charger_status_pkg::ADDR_STATUS_FOUR;
  localparam logic [7:0] A0 = charger_status_pkg::ADDR_FAULT_ZERO;
  localparam logic [1:0] OK = charger_status_pkg::RESP_OKAY;
  localparam logic [1:0] ER = charger_status_pkg::RESP_SLVERR;
  int bad_count = 0, n_compared = 0, cyc = 0;
  charger_status_fault_regs i_charger_status_fault_regs (.*);
  initial begin
    mclk_i = 1'h0;
    forever #50 mclk_i = ~mclk_i;
  end
  // ==========================================================
  // hang guard
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // ==========================================================
  // bus master, valid held until its ready is sampled
  task rchk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    logic t;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge mclk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    t = 1'h0;
    while (!t) begin
      @(negedge mclk_i);
      t = s_axi_arready_o;
      @(posedge mclk_i);
    end
    s_axi_arvalid_i <= 1'h0;
    t = 1'h0;
    while (!t) begin
      @(negedge mclk_i);
      t = s_axi_rvalid_o;
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      @(posedge mclk_i);
    end
    s_axi_rready_i <= 1'h0;
    chk("rdata", {24'h0, e}, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask : rchk
  task wr(input logic [7:0] a, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge mclk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= 32'hffffffff;
    s_axi_wstrb_i <= 4'hf;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    ta = 1'h0;
    tw = 1'h0;
    tb = 1'h0;
    while (!(ta && tw)) begin
      @(negedge mclk_i);
      ta |= s_axi_awready_o;
      tw |= s_axi_wready_o;
      @(posedge mclk_i);
      s_axi_awvalid_i <= !ta;
      s_axi_wvalid_i <= !tw;
    end
    while (!tb) begin
      @(negedge mclk_i);
      tb = s_axi_bvalid_o;
      r = s_axi_bresp_o;
      @(posedge mclk_i);
    end
    s_axi_bready_i <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask : wr
  // drive levels, then read all three with expectations from the bit map
  task chk_all(input logic [19:0] c, input logic [1:0] m);
    @(posedge mclk_i);
    cond_i <= c;
    mode_i <= m;
    repeat (4) @(posedge mclk_i);
    rchk(A3, {c[19:18], c[17] & m[1], c[16] & m[0], c[15:13], 1'h0}, OK);
    rchk(A4, {3'h0, c[12:8]}, OK);
    rchk(A0, c[7:0], OK);
  endtask : chk_all
  // ==========================================================
  // scenarios
  task t_walk;
    for (int i = 0; i < 20; i++)
      chk_all(20'h1 << i, 2'h3);
    $display("test walk done");
  endtask : t_walk
  task t_modes;
    for (int m = 0; m < 4; m++)
      chk_all(20'hfffff, m[1:0]);
    $display("test modes done");
  endtask : t_modes
  task t_write;
    chk_all(20'hfffff, 2'h3);
    wr(A3, OK);
    wr(A4, OK);
    wr(A0, OK);
    wr(8'h84, ER);
    rchk(8'h84, 8'h0, ER);
    chk_all(20'hfffff, 2'h3);
    chk_all(20'h0, 2'h3);
    $display("test write done");
  endtask : t_write
  initial begin
    rst_n_i = 1'h0;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i,
     s_axi_rready_i, s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i,
     s_axi_wstrb_i, cond_i, mode_i} = '0;
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'h1;
    rchk(A3, 8'h0, OK);
    rchk(A4, 8'h0, OK);
    rchk(A0, 8'h0, OK);
    $display("test reset done");
    t_walk();
    t_modes();
    t_write();
    stop_test();
  end
endmodule : test_charger_status_fault_regs
bind charger_status_fault_regs charger_status_chk i_charger_status_chk (.*);
